// *** include/pafmw_map.vh ***
// register offsets, field positions and reset values of the port a function mux
`ifndef PAFMW_MAP_VH
`define PAFMW_MAP_VH
`define PAFMW_ADDR_W 4
`define PAFMW_DATA_W 8
`define PAFMW_OFF_ALT_CFG 4'h0
`define PAFMW_OFF_IF_CFG 4'h1
`define PAFMW_OFF_FIFO_POL 4'h2
`define PAFMW_OFF_WAKE_CTRL 4'h3
`define PAFMW_OFF_PORT_OE 4'h4
`define PAFMW_OFF_PORT_OUT 4'h5
`define PAFMW_OFF_PORT_PINS 4'h6
`define PAFMW_OFF_IRQ_STAT 4'h7
`define PAFMW_OFF_IRQ_CLR 4'h8
`define PAFMW_OFF_IRQ_EN 4'h9
`define PAFMW_OFF_TRIG_SEL 4'hA
`define PAFMW_ALT_FIRST_BIT 0
`define PAFMW_ALT_SECOND_BIT 1
`define PAFMW_FIFO_OE_POL_BIT 4
`define PAFMW_WAKE_EN_BIT 1
`define PAFMW_WAKE_POL_BIT 4
`define PAFMW_WAKE_ROLE_BIT 7
`define PAFMW_WAKE_OE_BIT 3
`define PAFMW_TRIG_FIRST_BIT 0
`define PAFMW_TRIG_SECOND_BIT 1
`define PAFMW_IF_FIFO_MODE 2'h3
`define PAFMW_ST_FIRST_EDGE 0
`define PAFMW_ST_SECOND_EDGE 1
`define PAFMW_ST_WAKE 2
`define PAFMW_ST_FIFO_OE 3
`define PAFMW_RST_BYTE 8'h00
`define PAFMW_RST_NIB 4'h0
`define PAFMW_RST_IF 2'h0
`endif

// *** core/pafmw_core.v ***
// port a pins 0..3: port bits, interrupt inputs, fifo output enable and alternate wake source
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Function
// [R1] Pin zero is a port bit or the first interrupt input, picked by alternate-config bit 0.
// [R2] The first interrupt input is active low, edge triggered when its trigger bit is 1, level when 0.
// [R3] Pin one is a port bit or the second active-low interrupt input via alternate-config bit 1, edge/level likewise.
// [R4] Pin two is a port bit or the fifo output enable, picked by the two-bit interface-config field.
// [R5] In fifo mode pin two is input only and enables the fifo data drivers at the level set by polarity bit 4.
// [R6] The alternate wake source on pin three is enabled by wake-control bit 1 with polarity from bit 4.
// [R7] While suspended with wake enabled, a pin three transition restarts the oscillator and interrupts the cpu.
// [R8] While wake is enabled and pin three sits at its asserted level, suspend entry is refused.
// [R9] After reset all four pins are port-bit inputs with no alternate function active.
// [R10] Pin three takes its wake role from wake-control bit 7 together with port output-enable bit 3; the code takes it with bit 7 set and bit 3 clear.
`include "pafmw_map.vh"
module pafmw_core (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [`PAFMW_ADDR_W-1:0] reg_addr,
  input wire [`PAFMW_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`PAFMW_DATA_W-1:0] reg_rdata,
  // port a pins 0..3
  input wire [3:0] pin_in,
  output reg [3:0] pin_out,
  output reg [3:0] pin_oe,
  // processor interrupt inputs
  output reg ext_irq_first_n,
  output reg ext_irq_second_n,
  input wire irq_first_ack,
  input wire irq_second_ack,
  // slave fifo
  output reg fifo_drive_en,
  // suspend and wake
  input wire cpu_suspended,
  output reg osc_restart,
  output reg wake_irq,
  output reg suspend_block,
  // block interrupt
  output reg irq
);

  // configuration registers
  reg [7:0] port_alt_config_ff;
  reg [1:0] interface_config_ff;
  reg [7:0] fifo_pin_polarity_ff;
  reg [7:0] wake_ctrl_ff;
  reg [3:0] port_output_enable_ff;
  reg [3:0] port_out_ff;
  reg [1:0] trig_sel_ff;
  reg [3:0] irq_stat_ff;
  reg [3:0] irq_en_ff;

  // pin synchronisers
  reg [3:0] sync1_ff;
  reg [3:0] sync2_ff;
  reg [3:0] sync3_ff;
  reg [3:0] pin_stable_ff;
  reg [3:0] pin_prev_ff;

  // edge-held interrupt requests
  reg first_pend_ff;
  reg second_pend_ff;

  wire wr_alt = reg_wr && (reg_addr == `PAFMW_OFF_ALT_CFG);
  wire wr_if = reg_wr && (reg_addr == `PAFMW_OFF_IF_CFG);
  wire wr_pol = reg_wr && (reg_addr == `PAFMW_OFF_FIFO_POL);
  wire wr_wake = reg_wr && (reg_addr == `PAFMW_OFF_WAKE_CTRL);
  wire wr_oe = reg_wr && (reg_addr == `PAFMW_OFF_PORT_OE);
  wire wr_out = reg_wr && (reg_addr == `PAFMW_OFF_PORT_OUT);
  wire wr_clr = reg_wr && (reg_addr == `PAFMW_OFF_IRQ_CLR);
  wire wr_en = reg_wr && (reg_addr == `PAFMW_OFF_IRQ_EN);
  wire wr_trig = reg_wr && (reg_addr == `PAFMW_OFF_TRIG_SEL);

  // function selection
  wire sel_first = port_alt_config_ff[`PAFMW_ALT_FIRST_BIT]; // [R1]
  wire sel_second = port_alt_config_ff[`PAFMW_ALT_SECOND_BIT]; // [R3]
  wire sel_fifo = (interface_config_ff == `PAFMW_IF_FIFO_MODE); // [R4]
  wire sel_wake = wake_ctrl_ff[`PAFMW_WAKE_ROLE_BIT] && !port_output_enable_ff[`PAFMW_WAKE_OE_BIT]; // [R10]
  wire wake_en = sel_wake && wake_ctrl_ff[`PAFMW_WAKE_EN_BIT]; // [R6]
  wire wake_pol = wake_ctrl_ff[`PAFMW_WAKE_POL_BIT]; // [R6]
  wire fifo_pol = fifo_pin_polarity_ff[`PAFMW_FIFO_OE_POL_BIT]; // [R5]
  wire [3:0] alt_sel = {sel_wake, sel_fifo, sel_second, sel_first};

  // pin events seen on the filtered level
  wire [3:0] nxt_stable = (sync2_ff == sync3_ff) ? sync3_ff : pin_stable_ff;
  wire [3:0] pin_fall = pin_prev_ff & ~pin_stable_ff;
  wire [3:0] pin_change = pin_prev_ff ^ pin_stable_ff;

  wire first_edge = sel_first && pin_fall[0];
  wire second_edge = sel_second && pin_fall[1];
  wire wake_asserted = (pin_stable_ff[3] == wake_pol);
  wire wake_event = wake_en && cpu_suspended && pin_change[3]; // [R7]
  wire nxt_fifo_drive = sel_fifo && (pin_stable_ff[2] == fifo_pol); // [R5]

  // edge mode holds the request until the cpu acknowledges; set beats ack
  wire nxt_first_pend = first_edge || (first_pend_ff && !irq_first_ack && sel_first); // [R2]
  wire nxt_second_pend = second_edge || (second_pend_ff && !irq_second_ack && sel_second); // [R3]

  wire nxt_first_req = trig_sel_ff[`PAFMW_TRIG_FIRST_BIT] ? nxt_first_pend : (sel_first && !pin_stable_ff[0]); // [R2]
  wire nxt_second_req = trig_sel_ff[`PAFMW_TRIG_SECOND_BIT] ? nxt_second_pend :
                        (sel_second && !pin_stable_ff[1]); // [R3]

  wire [3:0] events = {(nxt_fifo_drive != fifo_drive_en), wake_event, second_edge, first_edge};
  wire [3:0] nxt_irq_stat = events | (irq_stat_ff & ~(wr_clr ? reg_wdata[3:0] : 4'h0));

  // registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_alt_config_ff <= `PAFMW_RST_BYTE; // [R9]
      interface_config_ff <= `PAFMW_RST_IF; // [R9]
      fifo_pin_polarity_ff <= `PAFMW_RST_BYTE;
      wake_ctrl_ff <= `PAFMW_RST_BYTE; // [R9]
      port_output_enable_ff <= `PAFMW_RST_NIB; // [R9]
      port_out_ff <= `PAFMW_RST_NIB;
      trig_sel_ff <= `PAFMW_RST_IF;
      irq_en_ff <= `PAFMW_RST_NIB;
    end else begin
      if (wr_alt) begin
        port_alt_config_ff <= reg_wdata;
      end
      if (wr_if) begin
        interface_config_ff <= reg_wdata[1:0];
      end
      if (wr_pol) begin
        fifo_pin_polarity_ff <= reg_wdata;
      end
      if (wr_wake) begin
        wake_ctrl_ff <= reg_wdata;
      end
      if (wr_oe) begin
        port_output_enable_ff <= reg_wdata[3:0];
      end
      if (wr_out) begin
        port_out_ff <= reg_wdata[3:0];
      end
      if (wr_trig) begin
        trig_sel_ff <= reg_wdata[1:0];
      end
      if (wr_en) begin
        irq_en_ff <= reg_wdata[3:0];
      end
    end
  end

  // synchronisers and event state
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= `PAFMW_RST_NIB;
      sync2_ff <= `PAFMW_RST_NIB;
      sync3_ff <= `PAFMW_RST_NIB;
      pin_stable_ff <= `PAFMW_RST_NIB;
      pin_prev_ff <= `PAFMW_RST_NIB;
      first_pend_ff <= 1'b0;
      second_pend_ff <= 1'b0;
      irq_stat_ff <= `PAFMW_RST_NIB;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_stable_ff <= nxt_stable;
      pin_prev_ff <= pin_stable_ff;
      first_pend_ff <= nxt_first_pend;
      second_pend_ff <= nxt_second_pend;
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // outputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= `PAFMW_RST_NIB;
      pin_oe <= `PAFMW_RST_NIB; // [R9]
      ext_irq_first_n <= 1'b1;
      ext_irq_second_n <= 1'b1;
      fifo_drive_en <= 1'b0;
      osc_restart <= 1'b0;
      wake_irq <= 1'b0;
      suspend_block <= 1'b0;
      irq <= 1'b0;
      reg_rdata <= `PAFMW_RST_BYTE;
    end else begin
      pin_out <= port_out_ff;
      // an alternate function never drives its pin
      pin_oe <= port_output_enable_ff & ~alt_sel; // [R1] [R3] [R5]
      ext_irq_first_n <= !nxt_first_req; // [R2]
      ext_irq_second_n <= !nxt_second_req; // [R3]
      fifo_drive_en <= nxt_fifo_drive; // [R5]
      osc_restart <= wake_event; // [R7]
      wake_irq <= wake_event; // [R7]
      suspend_block <= wake_en && wake_asserted; // [R8]
      irq <= |(nxt_irq_stat & irq_en_ff);
      if (reg_rd) begin
        case (reg_addr)
          `PAFMW_OFF_ALT_CFG: reg_rdata <= port_alt_config_ff;
          `PAFMW_OFF_IF_CFG: reg_rdata <= {6'h00, interface_config_ff};
          `PAFMW_OFF_FIFO_POL: reg_rdata <= fifo_pin_polarity_ff;
          `PAFMW_OFF_WAKE_CTRL: reg_rdata <= wake_ctrl_ff;
          `PAFMW_OFF_PORT_OE: reg_rdata <= {4'h0, port_output_enable_ff};
          `PAFMW_OFF_PORT_OUT: reg_rdata <= {4'h0, port_out_ff};
          `PAFMW_OFF_PORT_PINS: reg_rdata <= {4'h0, pin_stable_ff};
          `PAFMW_OFF_IRQ_STAT: reg_rdata <= {4'h0, irq_stat_ff};
          `PAFMW_OFF_IRQ_EN: reg_rdata <= {4'h0, irq_en_ff};
          `PAFMW_OFF_TRIG_SEL: reg_rdata <= {6'h00, trig_sel_ff};
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule // pafmw_core

// *** test/pafmw_core_properties.sv ***
// assertions on the port a function mux ports
`timescale 1ns/1ns
module pafmw_core_properties (
  // clock and reset
  input wire clk,
  input wire resetn,
  // pads, cpu and wake side
  input wire [3:0] pin_in,
  input wire [3:0] pin_oe,
  input wire ext_irq_first_n,
  input wire ext_irq_second_n,
  input wire fifo_drive_en,
  input wire cpu_suspended,
  input wire osc_restart,
  input wire wake_irq,
  input wire suspend_block
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_reset_quiet: assert property (!$past(resetn) |-> pin_oe == 4'h0 && ext_irq_first_n && !fifo_drive_en)
    else $error("outputs busy after reset");
  a_first_input: assert property (!ext_irq_first_n |-> !pin_oe[0]) else $error("pin 0 driven");
  a_second_input: assert property (!ext_irq_second_n |-> !pin_oe[1]) else $error("pin 1 driven");
  a_first_low: assert property ($fell(ext_irq_first_n) |-> !$past(pin_in[0], 3)) else $error("first high");
  a_second_low: assert property ($fell(ext_irq_second_n) |-> !$past(pin_in[1], 3)) else $error("second high");
  a_fifo_input: assert property (fifo_drive_en |-> !pin_oe[2]) else $error("pin 2 driven");
  a_wake_pair: assert property (osc_restart || wake_irq |-> osc_restart && wake_irq) else $error("wake split");
  a_wake_asleep: assert property (osc_restart |-> $past(cpu_suspended)) else $error("wake while awake");
  a_block_role: assert property (suspend_block |-> !pin_oe[3]) else $error("block with pin 3 driven");
  c_first_req: cover property ($fell(ext_irq_first_n));
  c_wake: cover property (osc_restart);
  c_block: cover property ($rose(suspend_block));
endmodule // pafmw_core_properties
bind pafmw_core pafmw_core_properties u_props (.clk, .resetn, .pin_in, .pin_oe, .ext_irq_first_n,
  .ext_irq_second_n, .fifo_drive_en, .cpu_suspended, .osc_restart, .wake_irq, .suspend_block);

// *** test/pafmw_board.sv ***
// board logic and fifo master on port a pins 0..3
`timescale 1ns/1ns
module pafmw_board (
  // clock and wanted levels with lag
  input wire clk,
  input wire [3:0] want,
  input wire [2:0] lag,
  // pads
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe,
  output wire [3:0] pin_in
);
  reg [3:0] lvl_ff = 4'hF;
  reg [2:0] cnt_ff = 3'h0;
  always @(posedge clk) begin
    cnt_ff <= (want == lvl_ff) ? 3'h0 : cnt_ff + 3'h1;
    if (want != lvl_ff && cnt_ff >= lag) lvl_ff <= want;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl_ff);
endmodule // pafmw_board

// *** test/pafmw_core_tb.sv ***
// self-checking bench of the port a function mux
`timescale 1ns/1ns
`include "pafmw_map.vh"
module pafmw_core_tb;
  reg clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, cpu_suspended = 1'h0, ack = 1'h0;
  reg [3:0] reg_addr = 4'h0, want = 4'hF;
  reg [7:0] reg_wdata = 8'h00, d;
  reg [2:0] lag = 3'h0;
  wire [7:0] reg_rdata;
  wire [3:0] pin_in, pin_out, pin_oe;
  wire ext_irq_first_n, ext_irq_second_n, fifo_drive_en, osc_restart, wake_irq, suspend_block, irq;
  integer failures = 0, n_compared = 0, n_osc = 0, n_wki = 0, seed = 2, i, m [0:15];
  pafmw_core u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out,
    .pin_oe, .ext_irq_first_n, .ext_irq_second_n, .irq_first_ack(ack), .irq_second_ack(ack), .fifo_drive_en,
    .cpu_suspended, .osc_restart, .wake_irq, .suspend_block, .irq);
  pafmw_board u_board (.clk, .want, .lag, .pin_out, .pin_oe, .pin_in);
  initial forever #5 clk = ~clk;
  always @(posedge clk) n_osc = n_osc + (osc_restart === 1'h1);
  always @(posedge clk) n_wki = n_wki + (wake_irq === 1'h1);
  initial #100000 test_done(1);
  task test_done(input integer late);
    failures = failures + late;
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [7:0] s, input [7:0] e, input string nm);
    n_compared = n_compared + 1;
    failures = failures + (s !== e);
    if (s !== e) $display("wrong value %0s expected %h seen %h", nm, e, s);
  endtask
  // one write, or one read compared with v
  task bus(input w, input [3:0] a, input [7:0] v);
    #1 if (w) m[a] = v;
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, v, w, !w};
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'h0;
    if (!w) #1 chk(reg_rdata, v, "rdata");
    if (!w) @(posedge clk);
  endtask
  task pins(input [3:0] w);
    want <= w;
    repeat (16) @(posedge clk);
    #1;
  endtask
  task wk(input [7:0] c, input o, input s, input p, input [3:0] e);
    bus(1, `PAFMW_OFF_WAKE_CTRL, c);
    bus(1, `PAFMW_OFF_PORT_OE, {4'h0, o, 3'h0});
    cpu_suspended <= s;
    pins({p, 3'h7});
    chk({suspend_block, n_osc[2:0]}, e, "wake");
    chk(n_wki[7:0], {5'h00, e[2:0]}, "wake irq");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    #1 chk({pin_oe, ext_irq_first_n, ext_irq_second_n, fifo_drive_en, suspend_block}, 8'h0C, "reset");
    repeat (8) @(posedge clk);
    for (i = 0; i < 16; i = i + 1) bus(0, i[3:0], (i == 6) ? 8'h0F : 8'h00);
    d = $random(seed);
    lag <= d[2:0];
    d = $random(seed);
    bus(1, `PAFMW_OFF_PORT_OUT, d);
    bus(1, `PAFMW_OFF_PORT_OE, 8'h0F);
    pins(4'h0);
    chk(pin_in, d[3:0], "port");
    bus(1, `PAFMW_OFF_PORT_OE, 8'h00);
    bus(1, `PAFMW_OFF_IRQ_EN, 8'h03);
    bus(1, `PAFMW_OFF_TRIG_SEL, 8'h01);
    pins(4'hF);
    bus(1, `PAFMW_OFF_ALT_CFG, 8'h03);
    pins(4'hC);
    chk({ext_irq_first_n, ext_irq_second_n, irq}, 3'h1, "irq low");
    pins(4'hF);
    chk({ext_irq_first_n, ext_irq_second_n}, 2'h1, "irq high");
    ack <= 1'h1;
    @(posedge clk);
    ack <= 1'h0;
    @(posedge clk);
    #1 chk(ext_irq_first_n, 1'h1, "irq ack");
    bus(0, `PAFMW_OFF_IRQ_STAT, 8'h03);
    bus(1, `PAFMW_OFF_IRQ_CLR, 8'h03);
    pins(4'hF);
    chk(irq, 1'h0, "irq clear");
    bus(1, `PAFMW_OFF_TRIG_SEL, 8'h02);
    pins(4'hC);
    chk({ext_irq_first_n, ext_irq_second_n}, 2'h0, "irq swap low");
    pins(4'hF);
    chk({ext_irq_first_n, ext_irq_second_n}, 2'h2, "irq swap held");
    bus(1, `PAFMW_OFF_ALT_CFG, 8'h00);
    bus(1, `PAFMW_OFF_PORT_OE, 8'h04);
    for (i = 0; i < 16; i = i + 1) begin
      bus(1, `PAFMW_OFF_FIFO_POL, {3'h0, i[0], 4'h0});
      bus(1, `PAFMW_OFF_IF_CFG, {6'h00, i[3:2]});
      pins({1'h1, i[1], 2'h3});
      chk({fifo_drive_en, pin_oe[2]}, {m[1] == 3 && i[1] == m[2][4], m[1] != 3}, "fifo");
    end
    bus(1, `PAFMW_OFF_IF_CFG, 8'h00);
    wk(8'h92, 1'h0, 1'h0, 1'h0, 4'h0);
    wk(8'h92, 1'h0, 1'h0, 1'h1, 4'h8);
    wk(8'h92, 1'h0, 1'h1, 1'h0, 4'h1);
    wk(8'h82, 1'h0, 1'h1, 1'h0, 4'h9);
    wk(8'h82, 1'h0, 1'h1, 1'h1, 4'h2);
    wk(8'h80, 1'h0, 1'h1, 1'h0, 4'h2);
    wk(8'h92, 1'h1, 1'h1, 1'h1, 4'h2);
    test_done(0);
  end
endmodule // pafmw_core_tb
